/* rtl/dro_pkg.sv */
/*
 Constants for the DRAM row organisation block: register offsets, field
 positions, reset values, memory technologies and per-technology timing.
 Assumes an 8-bit configuration port and 1-Mbyte address granularity.
*/
package dro_pkg;
   // Register offsets on the configuration port
   localparam logic [7:0] OFS_CTRL    = 8'h57;
   localparam logic [7:0] OFS_TIMING  = 8'h58;
   localparam logic [7:0] OFS_BOUND0  = 8'h60;
   localparam logic [7:0] OFS_TYPE_LO = 8'h68;
   localparam logic [7:0] OFS_TYPE_HI = 8'h69;
   localparam logic [7:0] OFS_VB_BASE = 8'h6A;
   localparam logic [7:0] OFS_VB_SIZE = 8'h6B;
   localparam logic [7:0] OFS_STATUS  = 8'h6C;
   localparam int         NUM_ROWS    = 5;
   // Control register fields
   localparam int CTRL_FIVE_ROW = 0;
   localparam int CTRL_GAP_EN   = 1;
   localparam int CTRL_GAP_SEL  = 2;
   localparam int CTRL_VB_EN    = 3;
   localparam int CTRL_SHARED   = 4;
   // Timing register fields
   localparam int TIM_WAIT      = 4;
   localparam int TIM_RATE_LO   = 5;
   localparam logic [1:0] RATE_SLOW = 2'h1;
   // Reset values
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [4:0] RST_CTRL   = 5'h00;
   // Memory technology codes per row
   typedef enum logic [1:0] {
      TECH_EDO   = 2'h0,
      TECH_SPM   = 2'h1,
      TECH_SDRAM = 2'h2
   } dro_tech_t;
   // Address limits in 1-Mbyte units, low gap in 128-Kbyte blocks
   localparam logic [11:0] MEM_CEIL_MB = 12'h080;
   localparam logic [11:0] GAP_HI_MB   = 12'h00F;
   localparam logic [14:0] GAP_LO_BLK  = 15'h0004;
   // Leadoff and burst clocks per technology
   localparam logic [3:0] LEAD_EDO   = 4'h6;
   localparam logic [3:0] LEAD_SPM   = 4'h6;
   localparam logic [3:0] LEAD_SDRAM = 4'h6;
   localparam logic [3:0] BURST_EDO  = 4'h2;
   localparam logic [3:0] BURST_SPM  = 4'h3;
   localparam logic [3:0] BURST_SDR  = 4'h1;
endpackage

/* rtl/dro_row_org.sv */
/*
 DRAM row organisation: decodes each host access against cumulative row
 boundaries, drives row strobes, chip selects and column strobes, picks
 per-row timing and forwards unreachable addresses to PCI.
 Assumes a host-clock synchronous access request held by the caller and a
 plain 8-bit configuration port with read data one cycle after the strobe.
*/
//
// Overview of operation
// - Four-row systems take EDO, page mode or SDRAM on a per-row basis.
// - Timing follows the technology of the row being accessed.
// - Each row has its own strobe; eight column strobes give byte lanes.
// - Rows may be populated in any order.
// - Five-row page-mode systems use the second column strobe pin as row strobe.
// - Five-row SDRAM systems use the mux select pin as fifth chip select.
// - Addressable memory never exceeds 128 Mbytes.
// - The wait-state bit adds one clock to leadoff and burst.
// - Above top, video buffer or gap goes to PCI, non-cacheable.
// - Memory under the video buffer or a gap is not remapped.
// - Addresses compare against cumulative boundaries to pick the row.
`timescale 1ns/1ps
module dro_row_org
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic      [7:0]  regRdData,
   input  wire logic        accValid,
   input  wire logic [31:3] accAddr,
   input  wire logic [7:0]  accByteEn,
   input  wire logic        cacheStrobeBN,
   input  wire logic        muxSelIn,
   output logic      [3:0]  rowStrobeN,
   output logic      [3:0]  chipSelectN,
   output logic      [7:0]  columnStrobeN,
   output logic             secondColumnStrobeBN,
   output logic             muxSelect,
   output logic             forwardPci,
   output logic             nonCacheable,
   output dro_pkg::dro_tech_t rowTech,
   output logic      [3:0]  leadoffClks,
   output logic      [3:0]  burstClks
);
   import dro_pkg::*;

   typedef struct packed {
      logic [7:0]      timing;
      logic [4:0]      ctrl;
      logic [4:0][7:0] bound;
      logic [4:0][1:0] tech;
      logic [7:0]      vbBase;
      logic [7:0]      vbSize;
      logic [7:0]      rdData;
      logic [3:0]      rasN;
      logic [3:0]      csN;
      logic            pinScasb;
      logic            pinMux;
      logic [7:0]      casN;
      logic            fwd;
      logic            nonCache;
      logic [1:0]      techOut;
      logic [3:0]      lead;
      logic [3:0]      burst;
      logic [2:0]      lastRow;
      logic            lastFwd;
   } dro_state_t;

   dro_state_t cur_ff;
   dro_state_t nxt_cur;

   logic [11:0] addrMb;
   logic [4:0]  rowHit;
   logic [11:0] topMb;
   logic [8:0]  vbEnd;
   logic        aboveTop;
   logic        inVb;
   logic        inGap;
   logic        fiveRow;
   logic [2:0]  hitIdx;
   logic [1:0]  hitTech;

   assign addrMb  = accAddr[31:20];
   assign fiveRow = cur_ff.ctrl[CTRL_FIVE_ROW];

   // Row hit per row from cumulative boundaries, any population order
   generate
      for (genvar i = 0; i < NUM_ROWS; i++)
      begin : g_row
         if (i == 0)
         begin : g_first
            assign rowHit[i] = {4'h0, cur_ff.bound[i]} > addrMb;
         end
         else
         begin : g_rest
            assign rowHit[i] = ({4'h0, cur_ff.bound[i]} > addrMb)
                             && ({4'h0, cur_ff.bound[i-1]} <= addrMb)
                             && ((i < 4) || fiveRow);
         end
      end
   endgenerate

   // Top of memory, capped at the ceiling; then forwarding windows
   always_comb
   begin
      topMb = fiveRow ? {4'h0, cur_ff.bound[4]} : {4'h0, cur_ff.bound[3]};
      if (topMb > MEM_CEIL_MB)
      begin
         topMb = MEM_CEIL_MB;
      end
      vbEnd    = {1'b0, cur_ff.vbBase} + {1'b0, cur_ff.vbSize};
      aboveTop = (accAddr[31:27] != 5'h00) || (addrMb >= topMb);
      inVb     = cur_ff.ctrl[CTRL_VB_EN]
               && (addrMb >= {4'h0, cur_ff.vbBase})
               && ({3'h0, vbEnd} > addrMb);
      inGap    = cur_ff.ctrl[CTRL_GAP_EN]
               && (cur_ff.ctrl[CTRL_GAP_SEL] ? (addrMb == GAP_HI_MB)
                                             : (accAddr[31:17] == GAP_LO_BLK));
   end

   // Encode the hit row and fetch its technology
   always_comb
   begin
      hitIdx  = 3'h0;
      hitTech = 2'h0;
      for (int j = NUM_ROWS - 1; j >= 0; j--)
      begin
         if (rowHit[j])
         begin
            hitIdx  = 3'(j);
            hitTech = cur_ff.tech[j];
         end
      end
   end

   // Next state: register port, access decode, pin sharing and timing
   always_comb
   begin
      nxt_cur          = cur_ff;
      nxt_cur.rdData   = 8'h00;
      nxt_cur.rasN     = 4'hF;
      nxt_cur.csN      = 4'hF;
      nxt_cur.casN     = 8'hFF;
      // Shared pins idle high as fifth-row selects; four-row pass-through below
      nxt_cur.pinScasb = 1'b1;
      nxt_cur.pinMux   = 1'b1;
      nxt_cur.fwd      = 1'b0;
      nxt_cur.nonCache = 1'b0;
      if (regWrStb)
      begin
         unique case (regAddr)
            OFS_CTRL:    nxt_cur.ctrl = regWrData[4:0];
            OFS_TIMING:  nxt_cur.timing = regWrData;
            OFS_TYPE_LO: nxt_cur.tech[3:0] = regWrData;
            OFS_TYPE_HI: nxt_cur.tech[4] = regWrData[1:0];
            OFS_VB_BASE: nxt_cur.vbBase = regWrData;
            OFS_VB_SIZE: nxt_cur.vbSize = regWrData;
            default:
            begin
               if (regAddr >= OFS_BOUND0 && regAddr < OFS_BOUND0 + 8'(NUM_ROWS))
               begin
                  nxt_cur.bound[3'(regAddr - OFS_BOUND0)] = regWrData;
               end
            end
         endcase
      end
      if (regRdStb)
      begin
         unique case (regAddr)
            OFS_CTRL:    nxt_cur.rdData = {3'h0, cur_ff.ctrl};
            OFS_TIMING:  nxt_cur.rdData = cur_ff.timing;
            OFS_TYPE_LO: nxt_cur.rdData = cur_ff.tech[3:0];
            OFS_TYPE_HI: nxt_cur.rdData = {6'h00, cur_ff.tech[4]};
            OFS_VB_BASE: nxt_cur.rdData = cur_ff.vbBase;
            OFS_VB_SIZE: nxt_cur.rdData = cur_ff.vbSize;
            OFS_STATUS:  nxt_cur.rdData = {4'h0, cur_ff.lastFwd, cur_ff.lastRow};
            default:
            begin
               if (regAddr >= OFS_BOUND0 && regAddr < OFS_BOUND0 + 8'(NUM_ROWS))
               begin
                  nxt_cur.rdData = cur_ff.bound[3'(regAddr - OFS_BOUND0)];
               end
            end
         endcase
      end
      if (accValid)
      begin
         if (aboveTop || inVb || inGap)
         begin
            nxt_cur.fwd      = 1'b1;
            nxt_cur.nonCache = 1'b1;
            nxt_cur.lastFwd  = 1'b1;
         end
         else if (rowHit != 5'h00)
         begin
            nxt_cur.lastFwd = 1'b0;
            nxt_cur.lastRow = hitIdx;
            nxt_cur.techOut = hitTech;
            nxt_cur.casN    = ~accByteEn;
            if (hitIdx == 3'h4)
            begin
               if (hitTech == TECH_SDRAM)
               begin
                  nxt_cur.pinMux = 1'b0;
               end
               else
               begin
                  nxt_cur.pinScasb = 1'b0;
               end
            end
            else if (hitTech == TECH_SDRAM)
            begin
               nxt_cur.csN[hitIdx[1:0]] = 1'b0;
            end
            else
            begin
               nxt_cur.rasN[hitIdx[1:0]] = 1'b0;
            end
            unique case (hitTech)
               TECH_SDRAM:
               begin
                  nxt_cur.lead  = LEAD_SDRAM;
                  nxt_cur.burst = BURST_SDR;
               end
               TECH_SPM:
               begin
                  nxt_cur.lead  = LEAD_SPM;
                  nxt_cur.burst = (cur_ff.timing[6:5] == RATE_SLOW) ? BURST_SPM + 4'h1 : BURST_SPM;
               end
               default:
               begin
                  nxt_cur.lead  = LEAD_EDO;
                  nxt_cur.burst = (cur_ff.timing[6:5] == RATE_SLOW) ? BURST_EDO + 4'h1 : BURST_EDO;
               end
            endcase
            if (cur_ff.timing[TIM_WAIT])
            begin
               nxt_cur.lead  = nxt_cur.lead + 4'h1;
               nxt_cur.burst = nxt_cur.burst + 4'h1;
            end
         end
      end
      // In five-row systems the shared pins hold their row meaning only
      if (!fiveRow)
      begin
         nxt_cur.pinScasb = cacheStrobeBN;
         nxt_cur.pinMux   = muxSelIn;
      end
   end

   // State register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cur_ff          <= '0;
         cur_ff.timing   <= RST_TIMING;
         cur_ff.ctrl     <= RST_CTRL;
         cur_ff.rasN     <= 4'hF;
         cur_ff.csN      <= 4'hF;
         cur_ff.casN     <= 8'hFF;
         cur_ff.pinScasb <= 1'b1;
         cur_ff.pinMux   <= 1'b1; // Fifth chip select stays inactive in reset
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs from flops
   assign regRdData            = cur_ff.rdData;
   assign rowStrobeN           = cur_ff.rasN;
   assign chipSelectN          = cur_ff.csN;
   assign columnStrobeN        = cur_ff.casN;
   assign secondColumnStrobeBN = cur_ff.pinScasb;
   assign muxSelect            = cur_ff.pinMux;
   assign forwardPci           = cur_ff.fwd;
   assign nonCacheable         = cur_ff.nonCache;
   assign rowTech              = dro_tech_t'(cur_ff.techOut);
   assign leadoffClks          = cur_ff.lead;
   assign burstClks            = cur_ff.burst;

   // Checks
   a_fwd_no_strobe: assert property (@(posedge clk) disable iff (!nrst)
      forwardPci |-> (rowStrobeN == 4'hF && chipSelectN == 4'hF && columnStrobeN == 8'hFF))
      else $error("strobe active on forwarded access");
   a_ceiling_fwd: assert property (@(posedge clk) disable iff (!nrst)
      (accValid && accAddr[31:27] != 5'h00) |=> (forwardPci && nonCacheable))
      else $error("access above ceiling not forwarded");
   a_one_select: assert property (@(posedge clk) disable iff (!nrst)
      $onehot0({~rowStrobeN, ~chipSelectN}))
      else $error("more than one row selected");
   a_select_cause: assert property (@(posedge clk) disable iff (!nrst)
      ((rowStrobeN != 4'hF) || (chipSelectN != 4'hF)) |-> $past(accValid))
      else $error("row select without access");
   a_lanes_follow: assert property (@(posedge clk) disable iff (!nrst)
      (rowStrobeN != 4'hF) |-> (columnStrobeN == ~$past(accByteEn)))
      else $error("column strobes not from byte enables");
   a_pin_pass: assert property (@(posedge clk) disable iff (!nrst)
      !$past(fiveRow) |-> (secondColumnStrobeBN == $past(cacheStrobeBN)))
      else $error("shared pin not passed through");
   a_sdram_pin: assert property (@(posedge clk) disable iff (!nrst)
      (!muxSelect && $past(muxSelIn)) |-> ($past(fiveRow) && $past(accValid) && $past(hitIdx) == 3'h4
       && $past(hitTech) == TECH_SDRAM))
      else $error("fifth chip select without five-row SDRAM");
   a_wait_state: assert property (@(posedge clk) disable iff (!nrst)
      (accValid && !inVb && !inGap && !aboveTop && rowHit != 5'h00 && cur_ff.timing[TIM_WAIT]
       && hitTech == TECH_SDRAM && !regWrStb)
      |=> (leadoffClks == LEAD_SDRAM + 4'h1 && burstClks == BURST_SDR + 4'h1))
      else $error("wait state not added");
   a_slow_rate: assert property (@(posedge clk) disable iff (!nrst)
      (accValid && !inVb && !inGap && !aboveTop && rowHit != 5'h00 && hitTech == TECH_EDO
       && cur_ff.timing[6:5] == RATE_SLOW && !cur_ff.timing[TIM_WAIT] && !regWrStb)
      |=> (burstClks == 4'h3 && rowTech == TECH_EDO))
      else $error("EDO slow burst not three clocks");
endmodule

/* test/dro_dram_rows.sv */
/*
 Far-side model of the DRAM rows: shows which row sees its row strobe or
 chip select in each cycle, and how many rows are selected at once.
 Assumes the bench tells it whether the fifth row is fitted.
*/
`timescale 1ns/1ps
module dro_dram_rows
(
   input  wire logic       fiveRow,
   input  wire logic [3:0] rowStrobeN,
   input  wire logic [3:0] chipSelectN,
   input  wire logic       scbPin,
   input  wire logic       muxPin,
   output logic      [2:0] selRow,
   output logic      [2:0] selCount
);
   logic [4:0] sel;

   // Each row is a pair of equal 32-bit modules, or one DIMM, behind one select
   assign sel = {fiveRow & (~scbPin | ~muxPin), ~(rowStrobeN & chipSelectN)};

   // Decode the selected row; a count above one means two rows answer at once
   always_comb
   begin
      selRow   = 3'h7;
      selCount = 3'h0;
      for (int i = 4; i >= 0; i--)
         if (sel[i])
         begin
            selRow   = 3'(i);
            selCount = selCount + 3'h1;
         end
   end
endmodule

/* test/dro_row_org_tb.sv */
/*
 Bench for the row organisation block: register and access tasks, then
 sequences of calls with expected values.
 Assumes dro_pkg and the far-side model dro_dram_rows.
*/
`timescale 1ns/1ps
module dro_row_org_tb;
   import dro_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWrData = 8'h00;
   logic        regWrStb = 1'b0;
   logic        regRdStb = 1'b0;
   logic [7:0]  regRdData;
   logic        accValid = 1'b0;
   logic [31:3] accAddr = '0;
   logic [7:0]  accByteEn = 8'h00;
   logic        cacheStrobeBN = 1'b1;
   logic        muxSelIn = 1'b1;
   logic [3:0]  rowStrobeN, chipSelectN, leadoffClks, burstClks;
   logic [7:0]  columnStrobeN;
   logic        secondColumnStrobeBN, muxSelect, forwardPci, nonCacheable;
   dro_tech_t   rowTech;
   dro_tech_t   typ [5];
   logic [2:0]  selRow, selCount;
   logic        fiveRow = 1'b0, slow = 1'b0, waitSt = 1'b0;
   int          errors = 0, checked = 0;

   // 125 MHz host clock
   always #4 clk = ~clk;

   dro_row_org dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .accValid(accValid),
      .accAddr(accAddr), .accByteEn(accByteEn), .cacheStrobeBN(cacheStrobeBN), .muxSelIn(muxSelIn),
      .rowStrobeN(rowStrobeN), .chipSelectN(chipSelectN), .columnStrobeN(columnStrobeN),
      .secondColumnStrobeBN(secondColumnStrobeBN), .muxSelect(muxSelect), .forwardPci(forwardPci),
      .nonCacheable(nonCacheable), .rowTech(rowTech), .leadoffClks(leadoffClks), .burstClks(burstClks));

   dro_dram_rows rows (.fiveRow(fiveRow), .rowStrobeN(rowStrobeN), .chipSelectN(chipSelectN),
      .scbPin(secondColumnStrobeBN), .muxPin(muxSelect), .selRow(selRow), .selCount(selCount));

   task automatic close_out();
      if (errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      @(posedge clk);
      regWrStb  <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, zero after that
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge clk);
      regRdStb <= 1'b0;
      #1 ck(regRdData, exp);
      @(posedge clk);
      #1 ck(regRdData, 8'h00);
   endtask

   task automatic setTypes();
      wr(OFS_TYPE_LO, {typ[3], typ[2], typ[1], typ[0]});
      wr(OFS_TYPE_HI, {6'h00, typ[4]});
   endtask

   // Cumulative row tops in Mbytes, row 0 in the low byte
   task automatic bounds(input logic [39:0] b);
      for (int i = 0; i < 5; i++)
         wr(OFS_BOUND0 + 8'(i), b[8*i +: 8]);
   endtask

   // Expected leadoff and burst clocks for a row technology
   function automatic logic [7:0] tim(input dro_tech_t t);
      logic [3:0] ld, bu;
      ld = (t == TECH_SDRAM) ? LEAD_SDRAM : (t == TECH_SPM) ? LEAD_SPM : LEAD_EDO;
      bu = (t == TECH_SDRAM) ? BURST_SDR : (t == TECH_SPM) ? BURST_SPM + 4'(slow) : BURST_EDO + 4'(slow);
      return {ld + 4'(waitSt), bu + 4'(waitSt)};
   endfunction

   // One host access; r is the expected row, 7 for forwarded to PCI
   task automatic acc(input logic [31:0] a, input logic [7:0] be, input int r);
      logic [3:0] rs, cs;
      logic       scb, ms, sdr;
      rs  = 4'hF;
      cs  = 4'hF;
      sdr = (r < 5) && (typ[r] == TECH_SDRAM);
      if (r < 4 && sdr)
         cs[r] = 1'b0;
      if (r < 4 && !sdr)
         rs[r] = 1'b0;
      @(posedge clk);
      scb       = (r == 4 && !sdr) ? 1'b0 : cacheStrobeBN;
      ms        = (r == 4 && sdr) ? 1'b0 : muxSelIn;
      accValid  <= 1'b1;
      accAddr   <= a[31:3];
      accByteEn <= be;
      @(posedge clk);
      accValid  <= 1'b0;
      #1 ck(rowStrobeN, rs);
      ck(chipSelectN, cs);
      ck({secondColumnStrobeBN, muxSelect}, {scb, ms});
      ck({forwardPci, nonCacheable}, {2{r == 7}});
      ck(selRow, r[2:0]);
      ck(selCount, (r == 7) ? 3'h0 : 3'h1);
      if (r < 7)
      begin
         ck(columnStrobeN, ~be);
         ck(rowTech, typ[r]);
         ck({leadoffClks, burstClks}, tim(typ[r]));
      end
   endtask

   // Watchdog well beyond the 135 or so cycles the sequence needs
   initial
   begin
      #40000;
      errors++;
      close_out();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_CTRL, 8'h00);
      rd(OFS_TIMING, RST_TIMING);
      rd(OFS_STATUS, 8'h00);
      wr(8'h70, 8'hFF);
      rd(8'h70, 8'h00);
      wr(OFS_TIMING, 8'hA5);
      rd(OFS_TIMING, 8'hA5);
      wr(OFS_TIMING, 8'h00);
      wr(OFS_CTRL, 8'hFF);
      rd(OFS_CTRL, 8'h1F);
      wr(OFS_CTRL, 8'h00);
      // Four rows with mixed technologies, row 1 left empty
      typ = '{TECH_EDO, TECH_SPM, TECH_SDRAM, TECH_SPM, TECH_EDO};
      setTypes();
      bounds({8'h28, 8'h20, 8'h18, 8'h08, 8'h08});
      acc(32'h0000_0000, 8'hFF, 0);
      acc(32'h0080_0000, 8'h0F, 2);
      cacheStrobeBN <= 1'b0;
      acc(32'h0180_0000, 8'h81, 3);
      cacheStrobeBN <= 1'b1;
      rd(OFS_STATUS, 8'h03);
      acc(32'h0200_0000, 8'hFF, 7);
      // Low gap, then high gap
      acc(32'h0008_0000, 8'hFF, 0);
      wr(OFS_CTRL, 8'h02);
      acc(32'h0008_0000, 8'hFF, 7);
      acc(32'h000A_0000, 8'hFF, 0);
      wr(OFS_CTRL, 8'h06);
      acc(32'h00F0_0000, 8'h3C, 7);
      acc(32'h00EF_FFF8, 8'h3C, 2);
      // Video buffer over 4 to 6 Mbytes, nothing remapped around it
      wr(OFS_VB_BASE, 8'h04);
      wr(OFS_VB_SIZE, 8'h02);
      wr(OFS_CTRL, 8'h08);
      acc(32'h0050_0000, 8'hFF, 7);
      acc(32'h0060_0000, 8'hFF, 0);
      acc(32'h003F_FFF8, 8'hFF, 0);
      // Added wait state with the slow burst rate
      wr(OFS_TIMING, 8'h30);
      slow   = 1'b1;
      waitSt = 1'b1;
      acc(32'h0000_0000, 8'hFF, 0);
      acc(32'h0080_0000, 8'hFF, 2);
      acc(32'h0180_0000, 8'hFF, 3);
      // Five EDO and page-mode rows: four 32-Mbyte rows, one cut to 24, 8-Mbyte fifth
      wr(OFS_TIMING, 8'h20);
      waitSt = 1'b0;
      typ = '{TECH_EDO, TECH_SPM, TECH_EDO, TECH_SPM, TECH_EDO};
      setTypes();
      wr(OFS_CTRL, 8'h01);
      fiveRow = 1'b1;
      bounds({8'h80, 8'h78, 8'h60, 8'h40, 8'h20});
      acc(32'h0780_0000, 8'hF0, 4);
      acc(32'h07F0_0000, 8'hFF, 4);
      acc(32'h0800_0000, 8'hFF, 7);
      acc(32'h0600_0000, 8'hFF, 3);
      // Five SDRAM rows, then the fifth row switched off by its boundary
      typ = '{5{TECH_SDRAM}};
      setTypes();
      acc(32'h07F0_0000, 8'h0F, 4);
      acc(32'h0000_0000, 8'hFF, 0);
      bounds({8'h80, 8'h80, 8'h60, 8'h40, 8'h20});
      acc(32'h07F0_0000, 8'hFF, 3);
      close_out();
   end
endmodule
